// ### core/uadc_regs.svh
// register offsets, fields, reset values and timing counts of the attach control block
// assumes a 32-bit plain register port with byte addresses
`ifndef UADC_REGS_SVH
`define UADC_REGS_SVH
`define UADC_OFS_CTRL      8'h00
`define UADC_OFS_PINS      8'h04
`define UADC_OFS_STAT      8'h08
`define UADC_CTRL_READY    0
`define UADC_CTRL_EXTPU    1
`define UADC_CTRL_SELFPWR  2
`define UADC_CTRL_WAKE     3
`define UADC_CTRL_RST      4'h0
`define UADC_PINS_RST      16'h3210
`define UADC_PWR_BUS       8'h32
`define UADC_PWR_SELF      8'h00
`define UADC_CLK_NS        8
`define UADC_FILT_NS       1000
`define UADC_FILT_CYC      ((`UADC_FILT_NS + `UADC_CLK_NS - 1) / `UADC_CLK_NS)
`endif

// ### core/uadc_pkg.sv
// types shared by the attach control block
// assumes nothing beyond a SystemVerilog tool
package uadc_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_ATTACHED, ST_DETACHED} uadc_state_e;
    typedef struct packed {
        logic [3:0] wake_pin;
        logic [3:0] detach_pin;
        logic [3:0] vbus_pin;
        logic [3:0] pullup_pin;
    } uadc_pins_s;
    typedef struct packed {
        logic wake_req;
        logic self_powered;
        logic ext_pullup;
        logic ready;
    } uadc_ctrl_s;
endpackage

// ### core/uadc_ctrl.sv
// attach, detach and wake control for a full-speed usb peripheral
// assumes one 125 MHz clock, 16 general io pins from outside, a same-clock packet engine
// What this block does
// - pull plus line high only when ready
// - select internal or external pull-up, internal default
// - external mode drives chosen pin high
// - self powered: no pull-up without vbus
// - vbus sense pin chosen by setting
// - bus powered reports 100 mA demand
// - detach and wake pins chosen by settings
// - detach high: lines high impedance, no pull-up
// - detach low: pull-up back, await enumeration
// - wake output active high, only while detached
// - no in-band wake while detached
// - bus powered suspend stops radio and loads
// - peripheral only, never host
//
// Strobed register access and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "uadc_regs.svh"
module uadc_ctrl
    import uadc_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic [15:0] general_io_pin_in,
    output logic      [15:0] general_io_pin_out,
    output logic      [15:0] general_io_pin_oe,
    input  wire logic        usb_suspend,
    output logic             plus_pullup_en,
    output logic             usb_lines_hiz,
    output logic             inband_wake_ok,
    output logic             radio_off,
    output logic             loads_off
);
    localparam logic [7:0] FILT_CYC = 8'(`UADC_FILT_CYC);

    function automatic logic pick_pin(input logic [15:0] v, input logic [3:0] idx);
        pick_pin = v[idx];
    endfunction

    uadc_ctrl_s  ctrl_reg, ctrl_next;
    uadc_pins_s  pins_reg, pins_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [15:0] sync1_reg, sync2_reg;
    logic [1:0]  filt_val;
    uadc_state_e state_reg, state_next;
    logic [15:0] gout_reg, gout_next, goe_reg, goe_next;
    logic        pu_reg, pu_next, hiz_reg, hiz_next;
    logic        iwake_reg, iwake_next, radio_reg, radio_next, loads_reg, loads_next;
    logic        detach_f, vbus_f, vbus_ok, want_attach;

    // two-stage synchroniser on the io pins
    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg <= 16'h0000;
            sync2_reg <= 16'h0000;
        end
        else
        begin
            sync1_reg <= general_io_pin_in;
            sync2_reg <= sync1_reg;
        end
    end

    // glitch filters: index 0 detach, index 1 vbus sense
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_filt
            logic [7:0] cnt_reg, cnt_next;
            logic       val_reg, val_next, raw;
            always_comb
            begin
                raw = (gi == 0) ? pick_pin(sync2_reg, pins_reg.detach_pin)
                                : pick_pin(sync2_reg, pins_reg.vbus_pin);
                val_next = val_reg;
                cnt_next = 8'h00;
                if (raw != val_reg)
                begin
                    cnt_next = cnt_reg + 8'h01;
                    if (cnt_next == FILT_CYC)
                    begin
                        val_next = raw;
                        cnt_next = 8'h00;
                    end
                end
            end
            always_ff @(posedge clk_sys or posedge rst)
            begin
                if (rst)
                begin
                    cnt_reg <= 8'h00;
                    val_reg <= 1'b0;
                end
                else
                begin
                    cnt_reg <= cnt_next;
                    val_reg <= val_next;
                end
            end
            assign filt_val[gi] = val_reg;
        end
    endgenerate

    assign detach_f    = filt_val[0];
    assign vbus_f      = filt_val[1];
    assign vbus_ok     = !ctrl_reg.self_powered || vbus_f;
    assign want_attach = ctrl_reg.ready && vbus_ok;

    // register port
    always_comb
    begin
        ctrl_next  = ctrl_reg;
        pins_next  = pins_reg;
        rdata_next = 32'h0000_0000;
        if (reg_wr)
        begin
            if (reg_addr == `UADC_OFS_CTRL)
                ctrl_next = reg_wdata[3:0];
            else if (reg_addr == `UADC_OFS_PINS)
                pins_next = reg_wdata[15:0];
        end
        if (reg_rd)
        begin
            if (reg_addr == `UADC_OFS_CTRL)
                rdata_next = {28'h0000000, ctrl_reg};
            else if (reg_addr == `UADC_OFS_PINS)
                rdata_next = {16'h0000, pins_reg};
            else if (reg_addr == `UADC_OFS_STAT)
                rdata_next = {16'h0000,
                              ctrl_reg.self_powered ? `UADC_PWR_SELF : `UADC_PWR_BUS,
                              2'b00, state_reg, usb_suspend, vbus_f, detach_f, pu_reg};
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            ctrl_reg  <= `UADC_CTRL_RST;
            pins_reg  <= `UADC_PINS_RST;
            rdata_reg <= 32'h0000_0000;
        end
        else
        begin
            ctrl_reg  <= ctrl_next;
            pins_reg  <= pins_next;
            rdata_reg <= rdata_next;
        end
    end

    // attach state machine and pin drive; only ever a peripheral, no host logic
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE:
                if (detach_f)
                    state_next = ST_DETACHED;
                else if (want_attach)
                    state_next = ST_ATTACHED;
            ST_ATTACHED:
                if (detach_f)
                    state_next = ST_DETACHED;
                else if (!want_attach)
                    state_next = ST_IDLE;
            ST_DETACHED:
                if (!detach_f)
                    state_next = ST_IDLE;
            default:
                state_next = ST_IDLE;
        endcase
        pu_next    = (state_next == ST_ATTACHED);
        hiz_next   = (state_next != ST_ATTACHED);
        iwake_next = (state_next == ST_ATTACHED);
        radio_next = usb_suspend && !ctrl_reg.self_powered;
        loads_next = usb_suspend && !ctrl_reg.self_powered;
        gout_next  = 16'h0000;
        goe_next   = 16'h0000;
        goe_next[pins_next.wake_pin]  = 1'b1;
        gout_next[pins_next.wake_pin] = (state_next == ST_DETACHED) && ctrl_next.wake_req;
        if (ctrl_next.ext_pullup)
        begin
            goe_next[pins_next.pullup_pin]  = 1'b1;
            gout_next[pins_next.pullup_pin] = pu_next;
            pu_next = 1'b0;
        end
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            state_reg <= ST_IDLE;
            pu_reg    <= 1'b0;
            hiz_reg   <= 1'b1;
            iwake_reg <= 1'b0;
            radio_reg <= 1'b0;
            loads_reg <= 1'b0;
            gout_reg  <= 16'h0000;
            goe_reg   <= 16'h0000;
        end
        else
        begin
            state_reg <= state_next;
            pu_reg    <= pu_next;
            hiz_reg   <= hiz_next;
            iwake_reg <= iwake_next;
            radio_reg <= radio_next;
            loads_reg <= loads_next;
            gout_reg  <= gout_next;
            goe_reg   <= goe_next;
        end
    end

    assign reg_rdata          = rdata_reg;
    assign general_io_pin_out = gout_reg;
    assign general_io_pin_oe  = goe_reg;
    assign plus_pullup_en     = pu_reg;
    assign usb_lines_hiz      = hiz_reg;
    assign inband_wake_ok     = iwake_reg;
    assign radio_off          = radio_reg;
    assign loads_off          = loads_reg;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    logic ext_pu_on;
    assign ext_pu_on = ctrl_reg.ext_pullup && gout_reg[pins_reg.pullup_pin]
                       && goe_reg[pins_reg.pullup_pin];

    // detach pin age: cycles its synchronised level has held, for the filter check
    logic       det_raw, det_last_reg, det_last_next;
    logic [7:0] det_age_reg, det_age_next;

    always_comb
    begin
        det_raw       = pick_pin(sync2_reg, pins_reg.detach_pin);
        det_last_next = det_raw;
        det_age_next  = 8'h01;
        if (det_raw == det_last_reg)
            det_age_next = (det_age_reg == 8'hFF) ? 8'hFF : det_age_reg + 8'h01;
    end

    always_ff @(posedge clk_sys or posedge rst)
    begin
        if (rst)
        begin
            det_last_reg <= 1'h0;
            det_age_reg  <= 8'h00;
        end
        else
        begin
            det_last_reg <= det_last_next;
            det_age_reg  <= det_age_next;
        end
    end

    sequence detach_held_s;
        detach_f [*2];
    endsequence

    sequence detach_drop_s;
        detach_f ##1 !detach_f;
    endsequence

    pullup_needs_ready_a: assert property ((pu_reg || ext_pu_on) |-> $past(ctrl_reg.ready))
        else $error("pull-up on while not ready");
    reset_int_pullup_a: assert property ($fell(rst) |-> !ctrl_reg.ext_pullup)
        else $error("external pull-up selected after reset");
    ext_mode_internal_off_a: assert property ($past(ctrl_next.ext_pullup) |-> !pu_reg)
        else $error("internal pull-up on in external mode");
    vbus_gates_pullup_a: assert property (
        ($past(ctrl_reg.self_powered) && !$past(vbus_f)) |-> !(pu_reg || ext_pu_on))
        else $error("pull-up on without vbus");
    power_report_a: assert property (
        (reg_rd && reg_addr == `UADC_OFS_STAT && !ctrl_reg.self_powered)
        |=> reg_rdata[15:8] == `UADC_PWR_BUS)
        else $error("bus powered current demand wrong");
    detach_floats_a: assert property (detach_held_s |=> usb_lines_hiz && !plus_pullup_en)
        else $error("lines driven while detached");
    detach_reconnect_a: assert property (
        (detach_drop_s ##0 want_attach [*2]) |=> (pu_reg || ext_pu_on))
        else $error("no reconnect after detach release");
    wake_only_detached_a: assert property (
        gout_reg[pins_reg.wake_pin] |-> $past(state_next) == ST_DETACHED)
        else $error("wake output while attached");
    no_inband_wake_a: assert property ($past(detach_f) |-> !inband_wake_ok)
        else $error("in-band wake allowed while detached");
    suspend_radio_a: assert property (
        (usb_suspend && !ctrl_reg.self_powered) |=> radio_off && loads_off)
        else $error("radio still on in bus powered suspend");
    filter_glitch_a: assert property (
        ($rose(sync2_reg[pins_reg.detach_pin]) && !detach_f) ##1
        !sync2_reg[pins_reg.detach_pin] |-> ##1 !detach_f)
        else $error("detach glitch passed the filter");
    filter_hold_a: assert property ($changed(detach_f) |-> det_age_reg >= FILT_CYC)
        else $error("detach level taken before it held long enough");
    ext_pin_drive_a: assert property (
        (ctrl_reg.ext_pullup && state_reg == ST_ATTACHED) |-> ext_pu_on && !plus_pullup_en)
        else $error("external pull-up pin not driven while attached");
endmodule

// ### dv/uadc_host_model.sv
// host side model: bus supply, detach line and suspend request
// assumes the device clock; levels change only at rising edges
`timescale 1ns/1ps
module uadc_host_model
(
    input  wire logic clk_sys,
    input  wire logic dev_pull,
    input  wire logic suspend_cmd,
    input  wire logic vbus_cmd,
    input  wire logic detach_cmd,
    output logic      usb_suspend,
    output logic      vbus_level,
    output logic      detach_level
);
    // the host only suspends a device it sees pulled up
    always_ff @(posedge clk_sys)
    begin
        usb_suspend  <= suspend_cmd && dev_pull;
        vbus_level   <= vbus_cmd;
        detach_level <= detach_cmd;
    end
endmodule

// ### dv/tb_usb_attach_detach_control.sv
// self-checking bench of the attach control block
// assumes the host model beside it and a 125 MHz clock
`timescale 1ns/1ps
`include "uadc_regs.svh"
module tb_usb_attach_detach_control
    import uadc_pkg::*;
;
    logic        clk_sys, rst = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, rd_seen = 1'h0;
    logic [7:0]  reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, lfsr = 32'h0001_6B8C;
    logic [15:0] gin, gout, goe;
    logic        usb_suspend, pull_en, hiz, wake_ok, radio_off, loads_off;
    logic        sus_cmd = 1'h0, vbus_cmd = 1'h0, det_cmd = 1'h0, vbus_lvl, det_lvl;
    logic [3:0]  vbus_pin = 4'h1, det_pin = 4'h2;
    int          mismatches = 0, check_count = 0, cycles = 0;
    logic [31:0] exp_q[$];

    uadc_ctrl dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .general_io_pin_in(gin),
        .general_io_pin_out(gout), .general_io_pin_oe(goe), .usb_suspend(usb_suspend),
        .plus_pullup_en(pull_en), .usb_lines_hiz(hiz), .inband_wake_ok(wake_ok),
        .radio_off(radio_off), .loads_off(loads_off));
    uadc_host_model host (.clk_sys(clk_sys), .dev_pull(pull_en | gout[0]),
        .suspend_cmd(sus_cmd), .vbus_cmd(vbus_cmd), .detach_cmd(det_cmd),
        .usb_suspend(usb_suspend), .vbus_level(vbus_lvl), .detach_level(det_lvl));

    // undriven pins read low
    always_comb
    begin
        gin = gout & goe;
        gin[vbus_pin] = vbus_lvl;
        gin[det_pin] = det_lvl;
    end

    initial
    begin
        clk_sys = 1'h0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("Error at %0t: expected %h got %h", $time, exp, got);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        reg_rd <= 1'h0;
        @(posedge clk_sys);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        reg_addr <= a;
        reg_rd <= 1'h1;
        reg_wr <= 1'h0;
        @(posedge clk_sys);
    endtask

    // idle cycles; strobes drop here so back-to-back accesses never assign twice
    task automatic cyc(input int n);
        reg_wr <= 1'h0;
        reg_rd <= 1'h0;
        repeat (n) @(posedge clk_sys);
    endtask

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // read data stand only in the cycle after the strobe
    always @(posedge clk_sys)
        rd_seen <= reg_rd;
    always @(negedge clk_sys)
        if (rd_seen)
            chk(exp_q.pop_front(), reg_rdata);

    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 4000)
        begin
            mismatches++;
            stop_test();
        end
    end

    initial
    begin
        cyc(10);
        rst <= 1'h0;
        cyc(2);
        chk(32'h4, {hiz, pull_en, wake_ok});
        rd(`UADC_OFS_CTRL, 32'h0);
        rd(`UADC_OFS_PINS, 32'h3210);
        rd(`UADC_OFS_STAT, 32'h3200);
        wr(8'h0C, 32'hFFFF_FFFF);
        rd(8'h0C, 32'h0);
        rd(`UADC_OFS_CTRL, 32'h0);
        wr(`UADC_OFS_CTRL, 32'h1);
        cyc(4);
        chk(32'h3, {hiz, pull_en, wake_ok});
        rd(`UADC_OFS_STAT, 32'h3211);
        sus_cmd <= 1'h1;
        cyc(4);
        chk(32'h3, {radio_off, loads_off});
        rd(`UADC_OFS_STAT, 32'h3219);
        sus_cmd <= 1'h0;
        cyc(4);
        chk(32'h0, {radio_off, loads_off});
        lfsr = lfsr_next(lfsr);
        det_pin = 4'h4 + {1'h0, lfsr[2:0]};
        vbus_pin = 4'hD;
        wr(`UADC_OFS_PINS, {16'h0, 4'hF, det_pin, vbus_pin, 4'h0});
        wr(`UADC_OFS_CTRL, 32'h7);
        cyc(4);
        chk(32'h1, {pull_en, gout[0], goe[0]});
        rd(`UADC_OFS_STAT, 32'h0);
        vbus_cmd <= 1'h1;
        cyc(140);
        chk(32'h6, {pull_en, gout[0], goe[0], hiz});
        rd(`UADC_OFS_STAT, 32'h14);
        sus_cmd <= 1'h1;
        cyc(4);
        chk(32'h0, {radio_off, loads_off});
        sus_cmd <= 1'h0;
        det_cmd <= 1'h1;
        cyc(1);
        det_cmd <= 1'h0;
        cyc(2);
        det_cmd <= 1'h1;
        cyc(40 + int'(lfsr[8:3]));
        det_cmd <= 1'h0;
        cyc(140);
        chk(32'h2, {gout[0], hiz});
        wr(`UADC_OFS_CTRL, 32'hF);
        cyc(2);
        chk(32'h1, {gout[15], goe[15]});
        det_cmd <= 1'h1;
        cyc(140);
        chk(32'h23, {hiz, pull_en, gout[0], wake_ok, gout[15], goe[15]});
        rd(`UADC_OFS_STAT, 32'h26);
        wr(`UADC_OFS_CTRL, 32'h7);
        cyc(2);
        chk(32'h1, {gout[15], goe[15]});
        det_cmd <= 1'h0;
        cyc(140);
        chk(32'h1, {hiz, gout[0]});
        cyc(2);
        stop_test();
    end
endmodule
